// File: core/afe_addr_if.sv
`timescale 1ns/100ps
interface afe_addr_if;
   logic [4:0]              cur_addr;
   logic                    is_write;
   afe_pkg::afe_rd_mode_type read_mode;
   logic                    write_inc;
   logic [4:0]              next_addr;
   modport seq  (input cur_addr, input is_write, input read_mode, input write_inc, output next_addr);
   modport regs (output cur_addr, output is_write, output read_mode, output write_inc, input next_addr);
endinterface

// File: core/afe_addr_seq.sv
`timescale 1ns/100ps
module afe_addr_seq (
   afe_addr_if.seq a
);
   logic [4:0] first;
   logic [4:0] last;

   always_comb begin
      first = a.cur_addr;
      last  = a.cur_addr;
      if (a.is_write) begin
         if (a.write_inc) begin
            first = afe_pkg::ADDR_CFG_FIRST;
            last  = afe_pkg::ADDR_LOCK;
         end
      end else begin
         case (a.read_mode)
            afe_pkg::AFE_RD_ALL: begin
               first = afe_pkg::ADDR_CH_FIRST;
               last  = afe_pkg::ADDR_LOCK;
            end
            afe_pkg::AFE_RD_TYPE: begin
               if (a.cur_addr <= afe_pkg::ADDR_CH_LAST) begin
                  first = afe_pkg::ADDR_CH_FIRST;
                  last  = afe_pkg::ADDR_CH_LAST;
               end else begin
                  first = afe_pkg::ADDR_CFG_FIRST;
                  last  = afe_pkg::ADDR_LOCK;
               end
            end
            afe_pkg::AFE_RD_GROUP: begin
               if (a.cur_addr <= afe_pkg::ADDR_CH_LAST) begin
                  first = {a.cur_addr[4:1], 1'b0};
                  last  = {a.cur_addr[4:1], 1'b1};
               end else if (a.cur_addr <= afe_pkg::ADDR_STATUS) begin
                  first = afe_pkg::ADDR_CFG_FIRST;
                  last  = afe_pkg::ADDR_STATUS;
               end else if (a.cur_addr <= afe_pkg::ADDR_CAL_LAST) begin
                  first = a.cur_addr[0] ? a.cur_addr : 5'(a.cur_addr - 5'h01);
                  last  = a.cur_addr[0] ? 5'(a.cur_addr + 5'h01) : a.cur_addr;
               end
            end
            default: begin
               first = a.cur_addr;
               last  = a.cur_addr;
            end
         endcase
      end
      if (a.cur_addr == last) begin
         a.next_addr = first;
      end else if (a.cur_addr == afe_pkg::ADDR_CAL_LAST) begin
         a.next_addr = afe_pkg::ADDR_LOCK;
      end else if (a.cur_addr == afe_pkg::ADDR_CH_LAST) begin
         a.next_addr = afe_pkg::ADDR_CFG_FIRST;
      end else begin
         a.next_addr = 5'(a.cur_addr + 5'h01);
      end
   end
endmodule // afe_addr_seq

// File: core/afe_cfg_regs.sv
`timescale 1ns/100ps
// Operation
// - delay write restarts all active converter channels
// - bits 23:12 hold pair 2/3 delay
// - bits 11:0 hold pair 0/1 delay
// - gain codes 0-5 map, 6-7 give one
// - read increment mode selects address looping
// - write increment loops writable map or holds
// - idle ready pin drives high or floats
// - merged mode: one pulse at last channel
// - unmerged mode: pulse per channel event
// - checksum width bit selects 16/32-bit word
// - data width code selects sample format
// - link checksum enable appends CRC-16
// - checksum error with interrupt holds pin low
// - lock equal to key clears interrupt
// - interrupt disabled: checksum mismatch raises nothing
// - ready flags low when ready, reset high
// - only status read sets flags back
// - unimplemented bits read zero, ignore writes
// - merged mode latches all active channel data together
module afe_cfg_regs #(
   parameter int PULSE_CYC = afe_pkg::DR_PULSE_CYC
) (
   input  wire logic        MCLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic [4:0]  REG_ADDR_I,
   input  wire logic        REG_WR_I,
   input  wire logic [23:0] REG_WDATA_I,
   input  wire logic        REG_RD_I,
   input  wire logic [3:0]  CONV_DONE_I,
   input  wire logic [3:0]  CH_ACTIVE_I,
   input  wire logic        CFG_CRC_ERR_I,
   input  wire logic [7:0]  LOCK_VALUE_I,
   output logic      [23:0] REG_RDATA_O,
   output logic      [4:0]  NEXT_ADDR_O,
   output logic      [11:0] PAIR23_DELAY_CODE_O,
   output logic      [11:0] PAIR01_DELAY_CODE_O,
   output logic      [11:0] CHANNEL_GAIN_CODE_O,
   output logic      [11:0] GAIN_SHIFT_O,
   output logic      [1:0]  READ_INC_MODE_O,
   output logic             WRITE_INC_O,
   output logic             CRC_WIDE_O,
   output logic      [1:0]  DATA_WIDTH_O,
   output logic             LINK_CHECKSUM_ENABLE_O,
   output logic      [3:0]  CHANNEL_READY_FLAGS_O,
   output logic      [3:0]  CH_RESTART_O,
   output logic      [3:0]  DATA_LATCH_O,
   output logic             CRC_INT_O,
   output logic             READY_PIN_O,
   output logic             READY_PIN_OE_O
);

   localparam int CNT_W = $clog2(PULSE_CYC + 1);

   if (PULSE_CYC < 1) begin : g_chk
      $error("PULSE_CYC must be at least one");
   end

   typedef struct packed {
      logic [23:0]      delay;
      logic [11:0]      gain;
      logic [11:0]      gain_shift;
      logic [1:0]       read_mode;
      logic             write_inc;
      logic             idle_drive;
      logic             merge;
      logic             crc_wide;
      logic [1:0]       data_width;
      logic             link_crc;
      logic             int_en;
      logic [3:0]       flags;
      logic [3:0]       pending;
      logic [CNT_W-1:0] pulse_cnt;
      logic             crc_int;
      logic [3:0]       restart;
      logic [3:0]       latch;
      logic [23:0]      rdata;
      logic [4:0]       next_addr;
      logic             pin_out;
      logic             pin_oe;
   } afe_state_type;

   afe_state_type q;
   afe_state_type d;
   afe_addr_if    addr_bus ();

   logic          rd_status;
   logic          wr_delay;
   logic          fire;
   logic [3:0]    pend_n;
   logic          pin_low;

   assign addr_bus.cur_addr  = REG_ADDR_I;
   assign addr_bus.is_write  = REG_WR_I;
   assign addr_bus.read_mode = afe_pkg::afe_rd_mode_type'(q.read_mode);
   assign addr_bus.write_inc = q.write_inc;

   afe_addr_seq u_seq (
      .a (addr_bus.seq)
   );

   always_comb begin
      d          = q;
      d.restart  = 4'h0;
      d.latch    = 4'h0;
      rd_status  = REG_RD_I && (REG_ADDR_I == afe_pkg::ADDR_STATUS);
      wr_delay   = REG_WR_I && (REG_ADDR_I == afe_pkg::ADDR_DELAY);
      fire       = 1'b0;
      pend_n     = q.pending | CONV_DONE_I;
      pin_low    = 1'b0;

      // register writes, unimplemented bits dropped
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            afe_pkg::ADDR_DELAY: begin
               d.delay = REG_WDATA_I;
            end
            afe_pkg::ADDR_GAIN: begin
               d.gain = REG_WDATA_I[11:0];
            end
            afe_pkg::ADDR_STATUS: begin
               d.read_mode  = REG_WDATA_I[afe_pkg::RD_INC_LSB +: 2];
               d.write_inc  = REG_WDATA_I[afe_pkg::WR_INC_BIT];
               d.idle_drive = REG_WDATA_I[afe_pkg::IDLE_DRV_BIT];
               d.merge      = REG_WDATA_I[afe_pkg::MERGE_BIT];
               d.crc_wide   = REG_WDATA_I[afe_pkg::CRC_WIDE_BIT];
               d.data_width = REG_WDATA_I[afe_pkg::DWIDTH_LSB +: 2];
               d.link_crc   = REG_WDATA_I[afe_pkg::LINK_CRC_BIT];
               d.int_en     = REG_WDATA_I[afe_pkg::INT_EN_BIT];
            end
            default: begin
               d.delay = q.delay;
            end
         endcase
      end

      // gain decode, reserved codes act as gain one
      for (int c = 0; c < afe_pkg::NUM_CH; c++) begin
         if (d.gain[c*3 +: 3] <= afe_pkg::GAIN_MAX_CODE) begin
            d.gain_shift[c*3 +: 3] = d.gain[c*3 +: 3];
         end else begin
            d.gain_shift[c*3 +: 3] = 3'h0;
         end
      end

      // restart active channels on delay write
      if (wr_delay) begin
         d.restart = CH_ACTIVE_I;
         d.pending = 4'h0;
      end else if (q.merge) begin
         if ((CH_ACTIVE_I != 4'h0) && ((pend_n & CH_ACTIVE_I) == CH_ACTIVE_I)) begin
            fire      = 1'b1;
            d.latch   = CH_ACTIVE_I;
            d.pending = 4'h0;
         end else begin
            d.pending = pend_n;
         end
      end else begin
         fire      = |CONV_DONE_I;
         d.latch   = CONV_DONE_I;
         d.pending = 4'h0;
      end

      // status read sets flags, a same-cycle event wins
      if (rd_status) begin
         d.flags = 4'hf;
      end
      d.flags = d.flags & ~CONV_DONE_I;

      // ready pulse counter
      if (fire) begin
         d.pulse_cnt = CNT_W'(PULSE_CYC);
      end else if (q.pulse_cnt != '0) begin
         d.pulse_cnt = CNT_W'(q.pulse_cnt - 1'b1);
      end

      // checksum interrupt, set wins over key clear
      if (LOCK_VALUE_I == afe_pkg::UNLOCK_KEY) begin
         d.crc_int = 1'b0;
      end
      if (q.int_en && CFG_CRC_ERR_I) begin
         d.crc_int = 1'b1;
      end

      // ready pin drive
      pin_low  = d.crc_int || (d.pulse_cnt != '0);
      d.pin_out = ~pin_low;
      d.pin_oe  = pin_low || d.idle_drive;

      // read data, zero for unimplemented bits
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            afe_pkg::ADDR_DELAY: begin
               d.rdata = q.delay;
            end
            afe_pkg::ADDR_GAIN: begin
               d.rdata = {12'h000, q.gain};
            end
            afe_pkg::ADDR_STATUS: begin
               d.rdata = {q.read_mode, q.write_inc, q.idle_drive, q.merge, q.crc_wide,
                          q.data_width, q.link_crc, q.int_en, 10'h000, q.flags};
            end
            default: begin
               d.rdata = 24'h000000;
            end
         endcase
      end

      if (REG_RD_I || REG_WR_I) begin
         d.next_addr = addr_bus.next_addr;
      end
   end

   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         q            <= '0;
         q.delay      <= afe_pkg::DELAY_RST;
         q.gain       <= afe_pkg::GAIN_RST;
         q.read_mode  <= afe_pkg::STATUS_RST[afe_pkg::RD_INC_LSB +: 2];
         q.write_inc  <= afe_pkg::STATUS_RST[afe_pkg::WR_INC_BIT];
         q.idle_drive <= afe_pkg::STATUS_RST[afe_pkg::IDLE_DRV_BIT];
         q.merge      <= afe_pkg::STATUS_RST[afe_pkg::MERGE_BIT];
         q.crc_wide   <= afe_pkg::STATUS_RST[afe_pkg::CRC_WIDE_BIT];
         q.data_width <= afe_pkg::STATUS_RST[afe_pkg::DWIDTH_LSB +: 2];
         q.flags      <= afe_pkg::STATUS_RST[afe_pkg::FLAGS_LSB +: 4];
         q.pin_out    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign REG_RDATA_O            = q.rdata;
   assign NEXT_ADDR_O            = q.next_addr;
   assign PAIR23_DELAY_CODE_O    = q.delay[afe_pkg::PAIR23_LSB +: afe_pkg::DELAY_W];
   assign PAIR01_DELAY_CODE_O    = q.delay[afe_pkg::PAIR01_LSB +: afe_pkg::DELAY_W];
   assign CHANNEL_GAIN_CODE_O    = q.gain;
   assign GAIN_SHIFT_O           = q.gain_shift;
   assign READ_INC_MODE_O        = q.read_mode;
   assign WRITE_INC_O            = q.write_inc;
   assign CRC_WIDE_O             = q.crc_wide;
   assign DATA_WIDTH_O           = q.data_width;
   assign LINK_CHECKSUM_ENABLE_O = q.link_crc;
   assign CHANNEL_READY_FLAGS_O  = q.flags;
   assign CH_RESTART_O           = q.restart;
   assign DATA_LATCH_O           = q.latch;
   assign CRC_INT_O              = q.crc_int;
   assign READY_PIN_O            = q.pin_out;
   assign READY_PIN_OE_O         = q.pin_oe;

endmodule // afe_cfg_regs

// File: core/afe_pkg.sv
package afe_pkg;
   localparam int             NUM_CH         = 4;
   localparam int             ADDR_W         = 5;
   localparam int             DATA_W         = 24;
   localparam int             GAIN_W         = 3;
   localparam int             DELAY_W        = 12;
   // register offsets
   localparam logic [4:0]     ADDR_CH_FIRST  = 5'h00;
   localparam logic [4:0]     ADDR_CH_LAST   = 5'h03;
   localparam logic [4:0]     ADDR_CFG_FIRST = 5'h08;
   localparam logic [4:0]     ADDR_DELAY     = 5'h0a;
   localparam logic [4:0]     ADDR_GAIN      = 5'h0b;
   localparam logic [4:0]     ADDR_STATUS    = 5'h0c;
   localparam logic [4:0]     ADDR_CAL_LAST  = 5'h16;
   localparam logic [4:0]     ADDR_LOCK      = 5'h1f;
   // field positions
   localparam int             PAIR23_LSB     = 12;
   localparam int             PAIR01_LSB     = 0;
   localparam int             RD_INC_LSB     = 22;
   localparam int             WR_INC_BIT     = 21;
   localparam int             IDLE_DRV_BIT   = 20;
   localparam int             MERGE_BIT      = 19;
   localparam int             CRC_WIDE_BIT   = 18;
   localparam int             DWIDTH_LSB     = 16;
   localparam int             LINK_CRC_BIT   = 15;
   localparam int             INT_EN_BIT     = 14;
   localparam int             FLAGS_LSB      = 0;
   // reset values
   localparam logic [23:0]    DELAY_RST      = 24'h000000;
   localparam logic [11:0]    GAIN_RST       = 12'h000;
   localparam logic [23:0]    STATUS_RST     = 24'ha9000f;
   localparam logic [2:0]     GAIN_MAX_CODE  = 3'h5;
   localparam logic [7:0]     UNLOCK_KEY     = 8'ha5;
   // ready pulse length in clock cycles
   localparam int             DR_PULSE_CYC   = 2;
   typedef enum logic [1:0] {
      AFE_RD_SAME  = 2'h0,
      AFE_RD_GROUP = 2'h1,
      AFE_RD_TYPE  = 2'h2,
      AFE_RD_ALL   = 2'h3
   } afe_rd_mode_type;
endpackage

// File: test/afe_cfg_regs_props.sv
`timescale 1ns/100ps
module afe_cfg_regs_props #(
   parameter int PULSE_CYC = 2
) (
   input wire logic        MCLK_I,
   input wire logic        SYS_RST_I,
   input wire logic [4:0]  REG_ADDR_I,
   input wire logic        REG_WR_I,
   input wire logic        REG_RD_I,
   input wire logic [3:0]  CONV_DONE_I,
   input wire logic [3:0]  CH_ACTIVE_I,
   input wire logic        CFG_CRC_ERR_I,
   input wire logic [7:0]  LOCK_VALUE_I,
   input wire logic [23:0] REG_RDATA_O,
   input wire logic [4:0]  NEXT_ADDR_O,
   input wire logic        WRITE_INC_O,
   input wire logic [3:0]  CHANNEL_READY_FLAGS_O,
   input wire logic [3:0]  CH_RESTART_O,
   input wire logic [3:0]  DATA_LATCH_O,
   input wire logic        CRC_INT_O,
   input wire logic        READY_PIN_O,
   input wire logic        READY_PIN_OE_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_delay_restart: assert property (REG_WR_I && REG_ADDR_I == 5'h0a |=> CH_RESTART_O == $past(CH_ACTIVE_I))
      else $error("restart mask wrong");
   a_int_holds_pin: assert property (CRC_INT_O |-> !READY_PIN_O && READY_PIN_OE_O)
      else $error("interrupt not holding pin low");
   a_key_clears_int: assert property (CRC_INT_O && LOCK_VALUE_I == 8'ha5 && !CFG_CRC_ERR_I |=> !CRC_INT_O)
      else $error("key did not clear interrupt");
   a_done_clears_flag: assert property (|CONV_DONE_I |=> (CHANNEL_READY_FLAGS_O & $past(CONV_DONE_I)) == 4'h0)
      else $error("flag not cleared on event");
   a_flag_rise_read: assert property (|(CHANNEL_READY_FLAGS_O & ~$past(CHANNEL_READY_FLAGS_O))
      |-> $past(REG_RD_I && REG_ADDR_I == 5'h0c))
      else $error("flag set without status read");
   a_latch_pin_low: assert property (|DATA_LATCH_O |-> !READY_PIN_O && READY_PIN_OE_O)
      else $error("latch without ready pulse");
   a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I[4:2] == 3'h1 |=> REG_RDATA_O == 24'h0)
      else $error("unmapped read not zero");
   a_wr_addr_same: assert property (REG_WR_I && !REG_RD_I && !WRITE_INC_O && REG_ADDR_I != 5'h0c
      |=> NEXT_ADDR_O == $past(REG_ADDR_I))
      else $error("write address moved");
   a_wr_addr_loop: assert property (REG_WR_I && !REG_RD_I && WRITE_INC_O && REG_ADDR_I == 5'h1f
      |=> NEXT_ADDR_O == 5'h08)
      else $error("write loop not back to start");
endmodule // afe_cfg_regs_props
bind afe_cfg_regs afe_cfg_regs_props #(.PULSE_CYC(PULSE_CYC)) u_props (
   .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .CONV_DONE_I(CONV_DONE_I), .CH_ACTIVE_I(CH_ACTIVE_I), .CFG_CRC_ERR_I(CFG_CRC_ERR_I), .LOCK_VALUE_I(LOCK_VALUE_I),
   .REG_RDATA_O(REG_RDATA_O), .NEXT_ADDR_O(NEXT_ADDR_O), .WRITE_INC_O(WRITE_INC_O), .CRC_INT_O(CRC_INT_O),
   .CHANNEL_READY_FLAGS_O(CHANNEL_READY_FLAGS_O), .CH_RESTART_O(CH_RESTART_O), .DATA_LATCH_O(DATA_LATCH_O),
   .READY_PIN_O(READY_PIN_O), .READY_PIN_OE_O(READY_PIN_OE_O)
);

// File: test/afe_cfg_regs_tb.sv
`timescale 1ns/100ps
module afe_cfg_regs_tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        wr, rd, err, winc, cwide, lcrc, cint, pin, oe;
   logic [3:0]  done, act, flags, rstrt, latch;
   logic [4:0]  addr, nxt;
   logic [7:0]  lock;
   logic [1:0]  rmode, dwid;
   logic [11:0] p23, p01, gcode, gshift;
   logic [23:0] wdata, rdata, q, w, g;
   int          fail_count = 0;
   int          n_compared = 0;
   afe_host_model u_host (.clk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
      .lock_o(lock));
   afe_cfg_regs #(.PULSE_CYC(2)) u_dut (.MCLK_I(mclk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_WDATA_I(wdata), .REG_RD_I(rd), .CONV_DONE_I(done), .CH_ACTIVE_I(act), .CFG_CRC_ERR_I(err),
      .LOCK_VALUE_I(lock), .REG_RDATA_O(rdata), .NEXT_ADDR_O(nxt), .PAIR23_DELAY_CODE_O(p23),
      .PAIR01_DELAY_CODE_O(p01), .CHANNEL_GAIN_CODE_O(gcode), .GAIN_SHIFT_O(gshift), .READ_INC_MODE_O(rmode),
      .WRITE_INC_O(winc), .CRC_WIDE_O(cwide), .DATA_WIDTH_O(dwid), .LINK_CHECKSUM_ENABLE_O(lcrc),
      .CHANNEL_READY_FLAGS_O(flags), .CH_RESTART_O(rstrt), .DATA_LATCH_O(latch), .CRC_INT_O(cint),
      .READY_PIN_O(pin), .READY_PIN_OE_O(oe));
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [2:0] exp_shift(input logic [2:0] c);
      return (c > 3'h5) ? 3'h0 : c;
   endfunction
   task automatic pulse(input logic [3:0] m, input logic e);
      @(posedge mclk);
      done <= m;
      err  <= e;
      @(posedge mclk);
      done <= 4'h0;
      err  <= 1'b0;
      #1;
   endtask
   task automatic wait_for(input logic [1:0] k);
      for (int i = 0; i < 4; i++) begin
         if ((k == 2'h0 && latch !== 4'h0) || (k == 2'h1 && cint === 1'b0)) return;
         @(posedge mclk);
         #1;
      end
      fail_count++;
      $display("CHECK FAILED wait_%0d expected event seen timeout", k);
      stop_test();
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
   initial begin
      void'($urandom(68180));
      done = 4'h0;
      act = 4'hf;
      err = 1'b0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      u_host.rd(5'h0a, q);
      chk("delay_rst", 24'h0, q);
      u_host.rd(5'h0b, q);
      chk("gain_rst", 24'h0, q);
      u_host.rd(5'h0c, q);
      chk("status_rst", 24'ha9000f, q);
      chk("oe_rst", 24'h0, 24'(oe));
      u_host.rd(5'h05, q);
      chk("unmapped", 24'h0, q);
      u_host.wr(5'h1f, 24'($urandom));
      chk("wr_loop", 24'h08, 24'(nxt));
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? 24'hfff000 : 24'($urandom);
         @(posedge mclk);
         act <= 4'($urandom);
         u_host.wr(5'h0a, w);
         chk("restart", 24'(act), 24'(rstrt));
         chk("pair23", 24'(w[23:12]), 24'(p23));
         chk("pair01", 24'(w[11:0]), 24'(p01));
         u_host.rd(5'h0a, q);
         chk("delay_rd", w, q);
      end
      $display("test delay done");
      for (int i = 0; i < 4; i++) begin
         w = (24'($urandom) & 24'h1cc000) | (24'(i) << 22) | (24'(i & 1) << 21) | (24'(i) << 16);
         g = (i == 0) ? 24'hfffde8 : 24'($urandom);
         u_host.wr(5'h0c, w);
         u_host.wr(5'h0b, g);
         for (int c = 0; c < 4; c++) chk("gain_shift", 24'(exp_shift(g[3*c+:3])), 24'(gshift[3*c+:3]));
         u_host.rd(5'h0b, q);
         chk("gain_rd", g & 24'h000fff, q);
         chk("gain_code", g & 24'h000fff, 24'(gcode));
         u_host.rd(5'h0c, q);
         chk("status_rd", (w & 24'hffc000) | 24'h00000f, q);
         chk("rd_mode", 24'(i), 24'(rmode));
         chk("data_width", 24'(i), 24'(dwid));
         chk("wr_inc", 24'(w[21]), 24'(winc));
         chk("crc_wide", 24'(w[18]), 24'(cwide));
         chk("link_crc", 24'(w[15]), 24'(lcrc));
      end
      $display("test status done");
      u_host.wr(5'h0c, 24'hb10000);
      @(posedge mclk);
      #1 chk("idle_hi", 24'h3, {22'h0, oe, pin});
      pulse(4'h4, 1'b0);
      chk("flags_evt", 24'hb, 24'(flags));
      chk("latch_one", 24'h4, 24'(latch));
      chk("pin_low", 24'h2, {22'h0, oe, pin});
      @(posedge mclk);
      #1 chk("pin_low2", 24'h0, 24'(pin));
      @(posedge mclk);
      #1 chk("pin_back", 24'h3, {22'h0, oe, pin});
      u_host.rd(5'h00, q);
      chk("flags_ch_rd", 24'hb, 24'(flags));
      u_host.rd(5'h0c, q);
      chk("flags_seen", 24'hb, 24'(q[3:0]));
      chk("flags_set", 24'hf, 24'(flags));
      u_host.wr(5'h0c, 24'ha10000);
      @(posedge mclk);
      #1 chk("idle_float", 24'h0, 24'(oe));
      @(posedge mclk);
      act <= 4'h3;
      u_host.wr(5'h0c, 24'ha90000);
      pulse(4'h1, 1'b0);
      repeat (2) @(posedge mclk);
      #1 chk("merge_wait", 24'h0, 24'(latch));
      chk("merge_quiet", 24'h0, 24'(oe));
      pulse(4'h2, 1'b0);
      wait_for(2'h0);
      chk("merge_latch", 24'h3, 24'(latch));
      chk("merge_pin", 24'h2, {22'h0, oe, pin});
      $display("test ready done");
      pulse(4'h0, 1'b1);
      @(posedge mclk);
      #1 chk("int_off", 24'h0, 24'(cint));
      u_host.wr(5'h0c, 24'ha94000);
      pulse(4'h0, 1'b1);
      repeat (4) @(posedge mclk);
      #1 chk("int_held", 24'h2, {22'h0, cint, pin});
      u_host.unlock(8'ha5);
      wait_for(2'h1);
      chk("int_clr", 24'h0, 24'(cint));
      $display("test interrupt done");
      stop_test();
   end
endmodule // afe_cfg_regs_tb

// File: test/afe_host_model.sv
`timescale 1ns/100ps
module afe_host_model (
   input  wire logic        clk_i,
   input  wire logic [23:0] rdata_i,
   output logic      [4:0]  addr_o,
   output logic             wr_o,
   output logic      [23:0] wdata_o,
   output logic             rd_o,
   output logic      [7:0]  lock_o
);
   initial begin
      addr_o = 5'h1f;
      wr_o = 1'b0;
      wdata_o = 24'h5a5a5a;
      rd_o = 1'b0;
      lock_o = 8'h00;
   end
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= (a == 5'h0c) ? (d & 24'hffcfff) : d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [23:0] q);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      #1 q = rdata_i;
   endtask
   task automatic unlock(input logic [7:0] v);
      @(posedge clk_i);
      lock_o <= v;
      #1;
   endtask
endmodule // afe_host_model
